// ==== taps_conv_model.sv ====
// Behavioural converter that answers stage conversion requests
module taps_conv_model (
	input  wire logic                     clk,
	input  wire logic                     reset,
	input  wire taps_pkg::taps_conv_req_t convReq,
	input  wire logic [7:0]               latency,
	input  wire logic [15:0]              stageVal [8],
	output taps_pkg::taps_conv_rsp_t      convRsp
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  cnt;
	logic [2:0]  stg;
	logic [15:0] last;
	// Data outside the done pulse is the inverse of the last result, so stale reads show
	always @(posedge clk)
	begin
		convRsp.done <= 1'b0;
		convRsp.data <= ~last;
		if (reset)
		begin
			cnt <= 8'h00;
			last <= 16'h0000;
		end
		else if (convReq.start)
		begin
			cnt <= latency;
			stg <= convReq.stage;
		end
		else if (cnt == 8'h01)
		begin
			convRsp.done <= 1'b1;
			convRsp.data <= stageVal[stg];
			last <= stageVal[stg];
			cnt <= 8'h00;
		end
		else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
	end
endmodule

// ==== taps_core.sv ====
// Touch activation logic, register file and power mode conversion sequencer
// Notes on behaviour
// - Each stage result goes to own register
// - Active only above upper or below lower limit
// - Limits kept per stage, updated by calibration
// - Limits start equal to programmed offsets
// - Mode field: 00 full, 10 low power
// - Modes 01 and 11 shut down conversions
// - Mode field resets to full power
// - Full power runs sequences back to back
// - Inactive results feed ambient compensation
// - Low power idle: sequence after programmed delay
// - Touched in low power: sequence every 25 ms
// - Timeout field sets return to reduced power
// - Low power stays reduced until proximity
// - Proximity switches to fast sequencing
// - Delay code gives 200/400/600/800 ms
// - Sequence runs stage zero to programmed last
module taps_core #(
	parameter int CYCLES_PER_MS = taps_pkg::CLK_HZ / taps_pkg::MS_PER_S
) (
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire taps_pkg::taps_reg_req_t     regReq,
	output taps_pkg::taps_reg_rsp_t          regRsp,
	input  wire taps_pkg::taps_conv_rsp_t    convRsp,
	output taps_pkg::taps_conv_req_t         convReq,
	output logic [taps_pkg::NUM_STAGES-1:0]  activeStages,
	output taps_pkg::taps_power_state_t      powerState
);
	localparam int NS    = taps_pkg::NUM_STAGES;
	localparam int DW    = taps_pkg::DATA_W;
	localparam int SW    = taps_pkg::STAGE_W;
	localparam int MW    = taps_pkg::MS_CNT_W;
	localparam int DIV_W = $clog2(CYCLES_PER_MS + 1);

	logic [DW-1:0]             powerCtl_r;
	logic [DW-1:0]             ambCtl_r;
	logic [DW-1:0]             stageEn_r;
	logic [DW-1:0]             result_r [NS];
	logic [DW-1:0]             upOff_r [NS];
	logic [DW-1:0]             loOff_r [NS];
	logic [DW-1:0]             upLim_r [NS];
	logic [DW-1:0]             loLim_r [NS];
	logic [NS-1:0]             actNxt;
	logic [1:0]                modeApplied_r;
	taps_pkg::taps_seq_state_t state_r;
	taps_pkg::taps_seq_state_t state_nxt;
	logic [SW-1:0]             curStage_r;
	logic [DIV_W-1:0]          divCnt_r;
	logic [MW-1:0]             msCnt_r;
	logic [MW-1:0]             idleMs_r;
	logic                      fast_r;

	// Register decode
	wire [9:0]    addr     = regReq.addr;
	wire          wrPower  = regReq.wr && (addr == taps_pkg::ADDR_POWER_CONTROL);
	wire          wrAmb    = regReq.wr && (addr == taps_pkg::ADDR_AMBIENT_COMP_CONTROL_0);
	wire          wrEnable = regReq.wr && (addr == taps_pkg::ADDR_STAGE_ENABLE);
	wire          inBanks  = addr[9:5] == taps_pkg::BANK_WINDOW;
	wire [1:0]    bankSel  = addr[4:3];
	wire [SW-1:0] bankIdx  = addr[2:0];
	// Limit banks are read-only; only the two offset banks take writes
	wire          wrAnyOff = regReq.wr && inBanks && !bankSel[1];
	wire          inResult = (addr >= taps_pkg::ADDR_RESULT_BASE)
		&& (addr <= taps_pkg::ADDR_RESULT_LAST);
	wire [9:0]    resOff   = addr - taps_pkg::ADDR_RESULT_BASE;
	wire [SW-1:0] resIdx   = resOff[SW-1:0];

	wire [DW-1:0] bankData =
		(bankSel == taps_pkg::BANK_UPPER_OFFSET) ? upOff_r[bankIdx] :
		(bankSel == taps_pkg::BANK_LOWER_OFFSET) ? loOff_r[bankIdx] :
		(bankSel == taps_pkg::BANK_UPPER_LIMIT)  ? upLim_r[bankIdx] : loLim_r[bankIdx];
	wire [DW-1:0] rdData =
		(addr == taps_pkg::ADDR_POWER_CONTROL)  ? powerCtl_r :
		(addr == taps_pkg::ADDR_AMBIENT_COMP_CONTROL_0) ? ambCtl_r :
		(addr == taps_pkg::ADDR_STAGE_ENABLE)   ? stageEn_r :
		inResult ? result_r[resIdx] :
		inBanks  ? bankData : '0;

	// Mode and timing selection
	wire [1:0]    modeField    = powerCtl_r[taps_pkg::MODE_LSB +: 2];
	wire          atBoundary   = (state_r == taps_pkg::SEQ_OFF) || (state_r == taps_pkg::SEQ_WAIT);
	wire          fullSel      = modeApplied_r == taps_pkg::MODE_FULL;
	wire          lowSel       = modeApplied_r == taps_pkg::MODE_LOW;
	wire          offSel       = !fullSel && !lowSel;
	wire [3:0]    seqLastField = powerCtl_r[taps_pkg::SEQ_LAST_LSB +: 4];
	// Codes past the last stage clamp rather than wrap
	wire [SW-1:0] seqLast      = (seqLastField >= 4'(NS)) ? SW'(NS - 1) : seqLastField[SW-1:0];
	wire [1:0]    delayCode    = powerCtl_r[taps_pkg::DELAY_LSB +: 2];
	wire [1:0]    timeoutCode  = ambCtl_r[taps_pkg::TIMEOUT_LSB +: 2];
	wire [MW-1:0] slowTarget   = MW'((int'(delayCode) + 1) * taps_pkg::LP_DELAY_STEP_MS);
	wire [MW-1:0] idleTarget   = MW'((int'(timeoutCode) + 1) * taps_pkg::IDLE_TIMEOUT_STEP_MS);
	wire [MW-1:0] fastTarget   = MW'(taps_pkg::TOUCH_PERIOD_MS);
	wire [MW-1:0] waitTarget   = fast_r ? fastTarget : slowTarget;
	wire          msTick       = divCnt_r == DIV_W'(CYCLES_PER_MS - 1);
	wire          convDone     = convRsp.done && (state_r == taps_pkg::SEQ_BUSY);
	// A last stage lowered mid-sequence ends it early rather than wrapping past stage 7
	wire          seqEnd       = convDone && (curStage_r >= seqLast);
	wire          anyTouch     = |activeStages;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			taps_pkg::SEQ_OFF:
				if (!offSel)
					state_nxt = taps_pkg::SEQ_ISSUE;
			taps_pkg::SEQ_WAIT:
				if (offSel)
					state_nxt = taps_pkg::SEQ_OFF;
				else if (fullSel)
					state_nxt = taps_pkg::SEQ_ISSUE;
				else if (msCnt_r >= waitTarget)
					state_nxt = taps_pkg::SEQ_ISSUE;
			taps_pkg::SEQ_ISSUE:
				state_nxt = taps_pkg::SEQ_BUSY;
			taps_pkg::SEQ_BUSY:
				if (convDone)
					state_nxt = seqEnd ? taps_pkg::SEQ_WAIT : taps_pkg::SEQ_ISSUE;
			default:
				state_nxt = taps_pkg::SEQ_OFF;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_r    <= taps_pkg::SEQ_WAIT;
			curStage_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_r == taps_pkg::SEQ_OFF || seqEnd)
				curStage_r <= '0;
			else if (convDone)
				curStage_r <= curStage_r + 1'b1;
		end
	end

	// Mode is sampled only between sequences so a running one is never cut
	always_ff @(posedge clk)
	begin
		if (reset)
			modeApplied_r <= taps_pkg::MODE_FULL;
		else if (atBoundary)
			modeApplied_r <= modeField;
	end

	always_ff @(posedge clk)
	begin
		if (reset || msTick)
			divCnt_r <= '0;
		else
			divCnt_r <= divCnt_r + 1'b1;
	end

	// Period is measured from the start of one sequence to the next
	always_ff @(posedge clk)
	begin
		if (reset || (state_r == taps_pkg::SEQ_ISSUE && curStage_r == '0))
			msCnt_r <= '0;
		else if (msTick && msCnt_r != '1)
			msCnt_r <= msCnt_r + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (reset || !lowSel)
			fast_r <= 1'b0;
		else if (anyTouch)
			fast_r <= 1'b1;
		else if (idleMs_r >= idleTarget)
			fast_r <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (reset || anyTouch || !fast_r)
			idleMs_r <= '0;
		else if (msTick && idleMs_r != '1)
			idleMs_r <= idleMs_r + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			powerCtl_r <= taps_pkg::POWER_CONTROL_RST;
			ambCtl_r   <= taps_pkg::AMB_COMP_RST;
			stageEn_r  <= taps_pkg::STAGE_ENABLE_RST;
		end
		else
		begin
			if (wrPower)
				powerCtl_r <= regReq.wdata;
			if (wrAmb)
				ambCtl_r <= regReq.wdata;
			if (wrEnable)
				stageEn_r <= regReq.wdata;
		end
	end

	for (genvar s = 0; s < NS; s++)
	begin : g_stage
		wire          hitStage = convDone && (curStage_r == SW'(s));
		wire [DW-1:0] data     = convRsp.data;
		wire          over     = data > upLim_r[s];
		wire          under    = data < loLim_r[s];
		// Only untouched readings move the limits, so a held finger is not learned
		wire          ambient  = hitStage && !(over || under);
		wire [DW:0]   upSum    = {1'b0, data} + {1'b0, upOff_r[s]};
		wire [DW-1:0] upTarget = upSum[DW] ? '1 : upSum[DW-1:0];
		wire [DW-1:0] loTarget = (data > loOff_r[s]) ? data - loOff_r[s] : '0;
		wire          wrUpOff  = wrAnyOff && (bankSel == taps_pkg::BANK_UPPER_OFFSET)
			&& (bankIdx == SW'(s));
		wire          wrLoOff  = wrAnyOff && (bankSel == taps_pkg::BANK_LOWER_OFFSET)
			&& (bankIdx == SW'(s));

		assign actNxt[s] = !stageEn_r[s] ? 1'b0 : hitStage ? (over || under) : activeStages[s];

		always_ff @(posedge clk)
		begin
			if (reset)
			begin
				result_r[s] <= '0;
				upOff_r[s]  <= taps_pkg::OFFSET_RST;
				loOff_r[s]  <= taps_pkg::OFFSET_RST;
				upLim_r[s]  <= taps_pkg::OFFSET_RST;
				loLim_r[s]  <= taps_pkg::OFFSET_RST;
			end
			else
			begin
				if (hitStage)
					result_r[s] <= data;
				if (wrUpOff)
				begin
					upOff_r[s] <= regReq.wdata;
					upLim_r[s] <= regReq.wdata;
				end
				else if (ambient && upLim_r[s] != upTarget)
					upLim_r[s] <= (upLim_r[s] < upTarget) ? upLim_r[s] + 1'b1 : upLim_r[s] - 1'b1;
				if (wrLoOff)
				begin
					loOff_r[s] <= regReq.wdata;
					loLim_r[s] <= regReq.wdata;
				end
				else if (ambient && loLim_r[s] != loTarget)
					loLim_r[s] <= (loLim_r[s] < loTarget) ? loLim_r[s] + 1'b1 : loLim_r[s] - 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			activeStages <= '0;
			convReq      <= '0;
			regRsp       <= '0;
			powerState   <= taps_pkg::PWR_FULL;
		end
		else
		begin
			activeStages  <= actNxt;
			convReq.start <= state_r == taps_pkg::SEQ_ISSUE;
			convReq.stage <= curStage_r;
			regRsp.valid  <= regReq.rd;
			regRsp.data   <= rdData;
			powerState    <= (state_r == taps_pkg::SEQ_OFF) ? taps_pkg::PWR_SHUTDOWN :
				fullSel ? taps_pkg::PWR_FULL :
				fast_r ? taps_pkg::PWR_FAST : taps_pkg::PWR_REDUCED;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	a_result_store: assert property (
		convDone |=> result_r[$past(curStage_r)] == $past(convRsp.data))
		else $error("Stage result not stored");

	a_active_compare: assert property (
		convDone && stageEn_r[curStage_r] |=> activeStages[$past(curStage_r)] ==
			(($past(convRsp.data) > $past(upLim_r[curStage_r]))
			|| ($past(convRsp.data) < $past(loLim_r[curStage_r]))))
		else $error("Activation does not match limits");

	a_limit_step: assert property (
		convDone && !wrAnyOff |=> (upLim_r[$past(curStage_r)] + 16'h0001
			- $past(upLim_r[curStage_r])) <= 16'h0002)
		else $error("Upper limit moved by more than one");

	a_offset_load: assert property (
		wrAnyOff && bankSel == taps_pkg::BANK_UPPER_OFFSET
			|=> upLim_r[$past(bankIdx)] == $past(regReq.wdata))
		else $error("Upper limit not loaded from offset");

	a_mode_reset: assert property (
		$past(reset) |-> modeField == taps_pkg::MODE_FULL && powerState == taps_pkg::PWR_FULL)
		else $error("Mode not full power after reset");

	a_shutdown_idle: assert property (
		state_r == taps_pkg::SEQ_OFF [*2] |-> !convReq.start)
		else $error("Conversion started in shutdown");

	a_full_backtoback: assert property (
		state_r == taps_pkg::SEQ_WAIT && fullSel
			|=> state_r == taps_pkg::SEQ_ISSUE ##1 convReq.start)
		else $error("Full power sequence not back to back");

	a_slow_wait: assert property (
		state_r == taps_pkg::SEQ_WAIT && lowSel && !fast_r && msCnt_r < slowTarget
			|=> state_r != taps_pkg::SEQ_ISSUE)
		else $error("Low power sequence before delay");

	a_fast_issue: assert property (
		state_r == taps_pkg::SEQ_WAIT && lowSel && fast_r && msCnt_r >= fastTarget
			|=> state_r == taps_pkg::SEQ_ISSUE)
		else $error("Touched sequence not started on period");

	a_wake_fast: assert property (
		lowSel && anyTouch |=> fast_r)
		else $error("Touch did not wake fast sequencing");

	a_idle_return: assert property (
		lowSel && fast_r && !anyTouch && idleMs_r >= idleTarget |=> !fast_r)
		else $error("No return to reduced power after timeout");

	a_mode_boundary: assert property (
		state_r == taps_pkg::SEQ_ISSUE || state_r == taps_pkg::SEQ_BUSY |=> $stable(modeApplied_r))
		else $error("Mode changed inside a sequence");

	a_seq_wrap: assert property (
		seqEnd |=> curStage_r == '0 && state_r == taps_pkg::SEQ_WAIT)
		else $error("Sequence did not end at last stage");

	c_seq_end: cover property (seqEnd && fullSel);
	c_wake: cover property (lowSel && !fast_r ##1 fast_r);
	c_shutdown: cover property (state_r == taps_pkg::SEQ_WAIT ##1 state_r == taps_pkg::SEQ_OFF);
endmodule

// ==== taps_pkg.sv ====
// Register map, field layout, timing constants and carrier types of the touch sequencer
package taps_pkg;
	localparam int ADDR_W     = 10;
	localparam int DATA_W     = 16;
	localparam int NUM_STAGES = 8;
	localparam int STAGE_W    = 3;

	localparam logic [9:0] ADDR_POWER_CONTROL  = 10'h000;
	localparam logic [9:0] ADDR_AMBIENT_COMP_CONTROL_0 = 10'h002;
	localparam logic [9:0] ADDR_STAGE_ENABLE   = 10'h003;
	localparam logic [9:0] ADDR_RESULT_BASE    = 10'h00B;
	localparam logic [9:0] ADDR_RESULT_LAST    = 10'h012;

	// Per-stage banks: addr[9:5] window, addr[4:3] bank, addr[2:0] stage
	localparam logic [4:0] BANK_WINDOW       = 5'h01;
	localparam logic [1:0] BANK_UPPER_OFFSET = 2'h0;
	localparam logic [1:0] BANK_LOWER_OFFSET = 2'h1;
	localparam logic [1:0] BANK_UPPER_LIMIT  = 2'h2;
	localparam logic [1:0] BANK_LOWER_LIMIT  = 2'h3;

	localparam int MODE_LSB     = 0;
	localparam int DELAY_LSB    = 2;
	localparam int SEQ_LAST_LSB = 4;
	localparam int TIMEOUT_LSB  = 12;

	localparam logic [1:0] MODE_FULL = 2'h0;
	localparam logic [1:0] MODE_LOW  = 2'h2;

	localparam logic [15:0] POWER_CONTROL_RST = 16'h0070;
	localparam logic [15:0] AMB_COMP_RST      = 16'h0000;
	localparam logic [15:0] STAGE_ENABLE_RST  = 16'h00FF;
	localparam logic [15:0] OFFSET_RST        = 16'h0000;

	localparam int CLK_HZ               = 100_000_000;
	localparam int MS_PER_S             = 1000;
	localparam int TOUCH_PERIOD_MS      = 25;
	localparam int LP_DELAY_STEP_MS     = 200;
	localparam int IDLE_TIMEOUT_STEP_MS = 500;
	localparam int MS_CNT_W             = 12;

	typedef enum logic [1:0] {SEQ_OFF, SEQ_WAIT, SEQ_ISSUE, SEQ_BUSY} taps_seq_state_t;
	typedef enum logic [1:0] {PWR_FULL, PWR_REDUCED, PWR_FAST, PWR_SHUTDOWN} taps_power_state_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} taps_reg_req_t;

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] data;
	} taps_reg_rsp_t;

	typedef struct packed {
		logic               start;
		logic [STAGE_W-1:0] stage;
	} taps_conv_req_t;

	typedef struct packed {
		logic              done;
		logic [DATA_W-1:0] data;
	} taps_conv_rsp_t;
endpackage

// ==== touch_activation_power_sequencer_tb.sv ====
// Self-checking bench for the touch sequencer core
module touch_activation_power_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CPMS = 10;
	logic                        clk;
	logic                        reset;
	taps_pkg::taps_reg_req_t     regReq;
	taps_pkg::taps_reg_rsp_t     regRsp;
	taps_pkg::taps_conv_req_t    convReq;
	taps_pkg::taps_conv_rsp_t    convRsp;
	logic [7:0]                  activeStages;
	taps_pkg::taps_power_state_t powerState;
	logic [7:0]                  latency;
	logic [15:0]                 stageVal [8];
	logic [15:0]                 rv;
	logic [2:0]                  seen [$];
	int                          fail_count;
	int                          samples_checked;
	int                          cyc;
	int                          t0;
	int                          t1;
	int                          k;
	taps_core #(.CYCLES_PER_MS(CPMS)) dut (.clk(clk), .reset(reset), .regReq(regReq),
		.regRsp(regRsp), .convRsp(convRsp), .convReq(convReq),
		.activeStages(activeStages), .powerState(powerState));
	taps_conv_model model (.clk(clk), .reset(reset), .convReq(convReq), .latency(latency),
		.stageVal(stageVal), .convRsp(convRsp));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Sampled mid-cycle so registered outputs launched on the rising edge have settled
	always @(negedge clk)
	begin
		cyc = cyc + 1;
		if (convReq.start === 1'b1)
		begin
			seen.push_back(convReq.stage);
			if (convReq.stage === 3'h0)
			begin
				t0 = t1;
				t1 = cyc;
			end
		end
		// Slow wake-up periods dominate the run; the ceiling covers them with margin
		if (cyc == 95000)
		begin
			fail_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cmpIn(input string n, input int lo, input int hi, input int g);
		samples_checked++;
		if (g < lo || g > hi)
		begin
			fail_count++;
			$display("CHECK FAILED %s exp %0d..%0d got %0d", n, lo, hi, g);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(negedge clk);
		regReq.wr = 1'b1;
		regReq.addr = a;
		regReq.wdata = d;
		@(negedge clk);
		regReq.wr = 1'b0;
	endtask
	task automatic rdReg(input logic [9:0] a);
		@(negedge clk);
		regReq.rd = 1'b1;
		regReq.addr = a;
		@(negedge clk);
		regReq.rd = 1'b0;
		rv = (regRsp.valid === 1'b1) ? regRsp.data : 16'hxxxx;
	endtask
	task automatic chk(input string n, input logic [9:0] a, input logic [15:0] e);
		rdReg(a);
		cmp(n, e, rv);
	endtask
	task automatic waitStart0();
		k = t1;
		while (t1 == k)
			@(negedge clk);
	endtask
	initial
	begin
		reset = 1'b1;
		regReq = '0;
		latency = 8'd20;
		for (int s = 0; s < 8; s++)
			stageVal[s] = 16'h8000 + 16'(s);
		fail_count = 0;
		samples_checked = 0;
		cyc = 0;
		t0 = 0;
		t1 = 0;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		cmp("powerState", 16'h0000, 16'(powerState));
		chk("power_control", taps_pkg::ADDR_POWER_CONTROL, 16'h0070);
		chk("amb_comp", taps_pkg::ADDR_AMBIENT_COMP_CONTROL_0, 16'h0000);
		chk("unmapped", 10'h3F0, 16'h0000);
		repeat (250) @(negedge clk);
		for (int s = 0; s < 8; s++)
		begin
			wr(taps_pkg::ADDR_RESULT_BASE + 10'(s), 16'h1234);
			chk("stage_result", taps_pkg::ADDR_RESULT_BASE + 10'(s), 16'h8000 + 16'(s));
		end
		wr(taps_pkg::ADDR_STAGE_ENABLE, 16'h0001);
		// Parked in shutdown so no calibration step moves the limits before they are read
		wr(taps_pkg::ADDR_POWER_CONTROL, 16'h0001);
		repeat (300) @(negedge clk);
		cmp("shutdown", 16'h0003, 16'(powerState));
		wr(10'h020, 16'h9000);
		wr(10'h028, 16'h7000);
		chk("upper_limit", 10'h030, 16'h9000);
		chk("lower_limit", 10'h038, 16'h7000);
		wr(taps_pkg::ADDR_POWER_CONTROL, 16'h0000);
		repeat (100) @(negedge clk);
		cmp("inactive", 16'h0000, 16'(activeStages[0]));
		rdReg(10'h038);
		// About four ambient conversions fit in the wait, one LSB each
		cmpIn("lower_step", 16'h6FF8, 16'h6FFF, int'(rv));
		cmp("lower_moved", 16'h0001, 16'(rv < 16'h7000));
		stageVal[0] = 16'hC000;
		repeat (100) @(negedge clk);
		cmp("above_upper", 16'h0001, 16'(activeStages[0]));
		chk("stage_result", taps_pkg::ADDR_RESULT_BASE, 16'hC000);
		stageVal[0] = 16'h4000;
		repeat (100) @(negedge clk);
		cmp("below_lower", 16'h0001, 16'(activeStages[0]));
		wr(taps_pkg::ADDR_STAGE_ENABLE, 16'h0000);
		repeat (100) @(negedge clk);
		cmp("disabled", 16'h0000, 16'(activeStages[0]));
		wr(taps_pkg::ADDR_STAGE_ENABLE, 16'h0001);
		stageVal[0] = 16'h8000;
		wr(taps_pkg::ADDR_POWER_CONTROL, 16'h0020);
		waitStart0();
		waitStart0();
		seen.delete();
		repeat (200) @(negedge clk);
		for (int i = 0; i < 6; i++)
			cmp("stage_order", 16'(i % 3 + 1) % 3, 16'(seen[i]));
		cmpIn("full_period", 3 * 20, 3 * 26, t1 - t0);
		for (int m = 1; m < 4; m += 2)
		begin
			wr(taps_pkg::ADDR_POWER_CONTROL, 16'h0020 | 16'(m));
			repeat (300) @(negedge clk);
			cmp("shutdown", 16'h0003, 16'(powerState));
			k = seen.size();
			repeat (300) @(negedge clk);
			cmpIn("no_conv", k, k, seen.size());
		end
		wr(taps_pkg::ADDR_POWER_CONTROL, 16'h0000);
		repeat (300) @(negedge clk);
		cmp("full_mode", 16'h0000, 16'(powerState));
		for (int d = 3; d >= 0; d--)
		begin
			wr(taps_pkg::ADDR_POWER_CONTROL, 16'h0002 | 16'(d << 2));
			waitStart0();
			waitStart0();
			waitStart0();
			k = (d + 1) * 200 * CPMS;
			cmpIn("sleep_period", k - CPMS, k + CPMS, t1 - t0);
			cmp("reduced", 16'h0001, 16'(powerState));
		end
		wr(taps_pkg::ADDR_AMBIENT_COMP_CONTROL_0, 16'h0000);
		stageVal[0] = 16'hC000;
		waitStart0();
		waitStart0();
		waitStart0();
		cmp("fast", 16'h0002, 16'(powerState));
		cmpIn("fast_period", 25 * CPMS - CPMS, 25 * CPMS + CPMS, t1 - t0);
		stageVal[0] = 16'h8000;
		repeat (4000) @(negedge clk);
		cmp("hold_fast", 16'h0002, 16'(powerState));
		for (int i = 0; i < 3000 && powerState !== taps_pkg::PWR_REDUCED; i++)
			@(negedge clk);
		cmp("back_reduced", 16'h0001, 16'(powerState));
		stop_test();
	end
endmodule
